// [design/vsw_ctrl_status_regs.sv]
// Control/status register bank with two-wire serial slave for a four-port video switch
// Behaviour
// - Read address byte is acknowledged by device
// - Device shifts selected register out MSB first
// - Master ack makes device send another byte
// - Status bits 6:5 give active port
// - Status bit 4 shows selected-port clock valid
// - Clock detect disabled forces status bit 4
// - Status bits 3:0 show port power senses
// - Status register read-only, tracks live conditions
// - Interrupt drops after status register read completes
// - Control bits 7:6 select power mode
// - Control bit 5 enables automatic port select
// - Control register writable and readable
// - Address 0101100 or 0101101 by select pin
// - Control bits 4:3 name the priority port
// - Config bit 7 disables clock detection
`timescale 1ns/1ps
module vsw_ctrl_status_regs
   import vsw_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       nrst_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       addr_sel_in,
   input  wire logic [3:0] source_power_sense_in,
   input  wire logic       link_clk_valid_in,
   output logic            irq_out,
   output logic [1:0]      power_mode_out,
   output logic            standby_out,
   output logic            deep_sleep_mode_out,
   output logic [1:0]      active_port_out,
   output logic            clk_detect_en_out
);
   // ==========================================================
   // Pin synchronisation
   logic [7:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic       asel_s;
   logic       clkv_s;
   logic [3:0] pwr_s;

   vsw_sync #(
      .WIDTH (8)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .nrst_in    (nrst_in),
      .async_in   ({scl_in, sda_in, addr_sel_in, link_clk_valid_in, source_power_sense_in}),
      .sync_out   (pins_sync)
   );

   assign {scl_s, sda_s, asel_s, clkv_s, pwr_s} = pins_sync;

   // ==========================================================
   // Register read decode
   function automatic logic [7:0] reg_read(input logic [3:0] ofs,
                                           input logic [7:0] st,
                                           input logic [7:0] ct,
                                           input logic [7:0] cf);
      logic [7:0] v;
      v = 8'h00;                     // Unmapped offsets read as zero
      case (ofs)
         OFS_PORT_STATUS:  v = st;
         OFS_PWR_SEL_CTRL: v = ct;
         OFS_LINK_CFG:     v = cf;
         default:          v = 8'h00;
      endcase
      return v;
   endfunction

   // ==========================================================
   // State
   vsw_ser_state_t state;
   vsw_ser_state_t next_state;
   vsw_ser_state_t after_ack;
   vsw_ser_state_t next_after_ack;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [3:0] ptr;
   logic [3:0] next_ptr;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic       drive;
   logic       next_drive;
   logic       master_ack;
   logic       next_master_ack;
   logic       st_byte;
   logic       next_st_byte;
   logic       scl_d;
   logic       sda_d;
   logic [7:0] status;
   logic [7:0] status_prev;
   logic       status_read_done;
   logic       next_irq;
   logic [1:0] sel_port;
   logic       irq;

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // ==========================================================
   // Port selection, automatic or manual
   logic [1:0] prio;
   logic [1:0] low_pwr;
   always_comb begin
      prio    = ctrl[CT_PRIO_LSB +: 2];
      low_pwr = prio;                                        // Nothing powered: keep priority
      for (int i = 3; i >= 0; i--) begin
         if (pwr_s[i]) begin
            low_pwr = 2'(i);
         end
      end
      if (ctrl[CT_AUTO_BIT]) begin
         sel_port = pwr_s[prio] ? prio : low_pwr;
      end else begin
         sel_port = cfg[CF_PORT_LSB +: 2];
      end
   end

   // ==========================================================
   // Live status word, never latched
   always_comb begin
      status                     = STATUS_RESET;
      status[ST_PORT_LSB +: 2]   = sel_port;
      status[ST_CLK_BIT]         = cfg[CF_CLKDIS_BIT] | clkv_s;
      status[3:0]                = pwr_s;
   end

   // ==========================================================
   // Serial engine next state
   always_comb begin
      next_state      = state;
      next_after_ack  = after_ack;
      next_cnt        = cnt;
      next_shreg      = shreg;
      next_ptr        = ptr;
      next_ctrl       = ctrl;
      next_cfg        = cfg;
      next_drive      = drive;
      next_master_ack = master_ack;
      next_st_byte    = st_byte;
      status_read_done = 1'b0;
      if (stop_c) begin
         next_state = SER_IDLE;
         next_drive = 1'b0;
      end else if (start_c) begin
         next_state = SER_ADDR;                              // Repeated start allowed anywhere
         next_cnt   = 4'h0;
         next_drive = 1'b0;
      end else begin
         case (state)
            SER_IDLE: begin
               next_drive = 1'b0;
            end
            SER_ADDR, SER_PTR, SER_WDATA: begin
               if (scl_rise && cnt < 4'h8) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_cnt   = cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_cnt   = 4'h0;
                  next_drive = 1'b1;                          // Pull low for the ack slot
                  next_state = SER_ACK_OUT;
                  if (state == SER_ADDR) begin
                     if (shreg[7:1] == {BUS_ADDR_HI, asel_s}) begin
                        next_after_ack = shreg[0] ? SER_RDATA : SER_PTR;
                     end else begin
                        next_drive = 1'b0;                   // Not ours: stay silent
                        next_state = SER_IDLE;
                     end
                  end else if (state == SER_PTR) begin
                     next_ptr       = shreg[3:0];
                     next_after_ack = SER_WDATA;
                  end else begin
                     if (ptr == OFS_PWR_SEL_CTRL) begin
                        next_ctrl = shreg;
                     end else if (ptr == OFS_LINK_CFG) begin
                        next_cfg = shreg & CFG_WRITE_MASK;
                     end
                     next_ptr       = ptr + 4'h1;
                     next_after_ack = SER_WDATA;
                  end
               end
            end
            SER_ACK_OUT: begin
               if (scl_fall) begin
                  next_cnt = 4'h0;
                  if (after_ack == SER_RDATA) begin
                     // Load the addressed register and present its MSB
                     next_shreg   = reg_read(ptr, status, ctrl, cfg);
                     next_st_byte = (ptr == OFS_PORT_STATUS);
                     next_ptr     = ptr + 4'h1;
                     next_drive   = ~next_shreg[7];
                  end else begin
                     next_drive = 1'b0;
                  end
                  next_state = after_ack;
               end
            end
            SER_RDATA: begin
               if (scl_fall) begin
                  if (cnt == 4'h7) begin
                     next_drive = 1'b0;                      // Release for the master's ack
                     next_state = SER_RACK;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_drive = ~shreg[6];
                     next_cnt   = cnt + 4'h1;
                  end
               end
            end
            SER_RACK: begin
               if (scl_rise) begin
                  next_master_ack  = ~sda_s;
                  status_read_done = st_byte;
               end else if (scl_fall) begin
                  if (master_ack) begin
                     next_shreg   = reg_read(ptr, status, ctrl, cfg);
                     next_st_byte = (ptr == OFS_PORT_STATUS);
                     next_ptr     = ptr + 4'h1;
                     next_drive   = ~next_shreg[7];
                     next_cnt     = 4'h0;
                     next_state   = SER_RDATA;
                  end else begin
                     next_state = SER_IDLE;
                     next_drive = 1'b0;
                  end
               end
            end
            default: begin
               next_state = SER_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Serial engine and control registers
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state      <= SER_IDLE;
         after_ack  <= SER_IDLE;
         cnt        <= 4'h0;
         shreg      <= 8'h00;
         ptr        <= 4'h0;
         ctrl       <= CTRL_RESET;
         cfg        <= CFG_RESET;
         drive      <= 1'b0;
         master_ack <= 1'b0;
         st_byte    <= 1'b0;
         scl_d      <= 1'b1;
         sda_d      <= 1'b1;
      end else begin
         state      <= next_state;
         after_ack  <= next_after_ack;
         cnt        <= next_cnt;
         shreg      <= next_shreg;
         ptr        <= next_ptr;
         ctrl       <= next_ctrl;
         cfg        <= next_cfg;
         drive      <= next_drive;
         master_ack <= next_master_ack;
         st_byte    <= next_st_byte;
         scl_d      <= scl_s;
         sda_d      <= sda_s;
      end
   end

   // ==========================================================
   // Interrupt: a change in the same cycle as the read wins
   always_comb begin
      next_irq = irq;
      if (status_read_done) begin
         next_irq = 1'b0;
      end
      if (status != status_prev) begin
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq         <= 1'b0;
         status_prev <= STATUS_RESET;
      end else begin
         irq         <= next_irq;
         status_prev <= status;
      end
   end

   // ==========================================================
   // Registered outputs; the pin is open drain so data low is the only drive
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_out             <= 1'b0;
         sda_oe_out          <= 1'b0;
         irq_out             <= 1'b0;
         power_mode_out      <= MODE_NORMAL;
         standby_out         <= 1'b0;
         deep_sleep_mode_out <= 1'b0;
         active_port_out     <= 2'h0;
         clk_detect_en_out   <= 1'b1;
      end else begin
         sda_out             <= 1'b0;
         sda_oe_out          <= next_drive;
         irq_out             <= next_irq;
         power_mode_out      <= ctrl[CT_MODE_LSB +: 2];
         standby_out         <= (ctrl[CT_MODE_LSB +: 2] == MODE_STANDBY);
         deep_sleep_mode_out <= ctrl[CT_MODE_LSB + 1];                   // 10 and 11 both
         active_port_out     <= sel_port;
         clk_detect_en_out   <= ~cfg[CF_CLKDIS_BIT];
      end
   end
endmodule

// [design/vsw_pkg.sv]
// Shared constants for the video switch control and status register bank
package vsw_pkg;
   // ==========================================================
   // Bus addressing
   localparam logic [5:0] BUS_ADDR_HI      = 6'h16;  // 010110, last bit from select pin
   localparam logic [3:0] PTR_UPPER_ZERO   = 4'h0;

   // ==========================================================
   // Register offsets
   localparam logic [3:0] OFS_PORT_STATUS  = 4'h1;
   localparam logic [3:0] OFS_PWR_SEL_CTRL = 4'h2;
   localparam logic [3:0] OFS_LINK_CFG     = 4'h3;

   // ==========================================================
   // Field positions
   localparam int ST_PORT_LSB   = 5;
   localparam int ST_CLK_BIT    = 4;
   localparam int CT_MODE_LSB   = 6;
   localparam int CT_AUTO_BIT   = 5;
   localparam int CT_PRIO_LSB   = 3;
   localparam int CF_CLKDIS_BIT = 7;
   localparam int CF_PORT_LSB   = 5;

   // ==========================================================
   // Reset values and masks
   localparam logic [7:0] CTRL_RESET       = 8'h00;
   localparam logic [7:0] CFG_RESET        = 8'h08;
   localparam logic [7:0] CFG_WRITE_MASK   = 8'hF8;  // Low three bits reserved, read as 0
   localparam logic [7:0] STATUS_RESET     = 8'h00;

   // ==========================================================
   // Power modes
   localparam logic [1:0] MODE_NORMAL      = 2'h0;
   localparam logic [1:0] MODE_STANDBY     = 2'h1;

   // ==========================================================
   // Serial engine states
   typedef enum logic [3:0] {
      SER_IDLE,
      SER_ADDR,
      SER_PTR,
      SER_WDATA,
      SER_ACK_OUT,
      SER_RDATA,
      SER_RACK
   } vsw_ser_state_t;
endpackage

// [design/vsw_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module vsw_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // ==========================================================
   // Synchroniser chain: first stage feeds only the second
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// [sim/vsw_regs_sva.sv]
// Port-level assertions for the video switch register bank
`timescale 1ns/1ps
module vsw_regs_sva (
   input wire logic       ref_clk_in,
   input wire logic       nrst_in,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic [3:0] source_power_sense_in,
   input wire logic       irq_out,
   input wire logic [1:0] power_mode_out,
   input wire logic       standby_out,
   input wire logic       deep_sleep_mode_out
);
   // ==========================================================
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   a_deep_sleep_map: assert property (deep_sleep_mode_out == power_mode_out[1])
      else $error("deep sleep flag disagrees with power mode");
   a_standby_map: assert property (standby_out == (power_mode_out == 2'h1))
      else $error("standby flag disagrees with power mode");
   a_open_drain: assert property (sda_oe_out |-> !sda_out)
      else $error("data line driven high");
   // Data may only move while the clock is low, else it reads as start or stop
   a_sda_edge_low: assert property ($changed(sda_oe_out) |-> !scl_in)
      else $error("data drive changed while clock high");
   a_ack_stands: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
      else $error("low drive released too early");
   a_irq_on_change: assert property ($changed(source_power_sense_in) |-> ##[1:8] irq_out)
      else $error("status change raised no interrupt");
   a_irq_clear_slot: assert property ($fell(irq_out) |-> scl_in)
      else $error("interrupt dropped outside an acknowledge slot");
   a_quiet_reset: assert property ($rose(nrst_in) |-> !sda_oe_out [*4])
      else $error("data line driven right after reset");
endmodule

bind vsw_ctrl_status_regs vsw_regs_sva vsw_regs_sva_i (
   .ref_clk_in            (ref_clk_in),
   .nrst_in               (nrst_in),
   .scl_in                (scl_in),
   .sda_out               (sda_out),
   .sda_oe_out            (sda_oe_out),
   .source_power_sense_in (source_power_sense_in),
   .irq_out               (irq_out),
   .power_mode_out        (power_mode_out),
   .standby_out           (standby_out),
   .deep_sleep_mode_out   (deep_sleep_mode_out)
);

// [sim/vsw_bus_master.sv]
// Two-wire bus master model standing in for the sink microcontroller
`timescale 1ns/1ps
module vsw_bus_master (
   input  wire logic ref_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_oe_out
);
   // ==========================================================
   // Bus idles released; each clock half lasts eight cycles
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   // Data moves mid-way through clock low, away from both edges
   task automatic bit_x(input logic b, output logic r);
      wait_clk(3);
      sda_oe_out <= ~b;
      wait_clk(5);
      scl_out <= 1'b1;
      wait_clk(8);
      r = sda_in;
      scl_out <= 1'b0;
   endtask

   // Start (also repeated) or stop condition
   task automatic cond(input logic is_start);
      wait_clk(3);
      sda_oe_out <= ~is_start;
      wait_clk(5);
      scl_out <= 1'b1;
      wait_clk(8);
      sda_oe_out <= is_start;
      wait_clk(8);
      if (is_start) scl_out <= 1'b0;
   endtask

   // Eight bits MSB first, then the ninth slot
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic r);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(last, r);
   endtask
endmodule

// [sim/vsw_ctrl_status_regs_tb_top.sv]
// Self-checking bench for the video switch register bank
`timescale 1ns/1ps
module vsw_ctrl_status_regs_tb_top;
   logic       ref_clk_in;
   logic       nrst_in;
   logic       addr_sel_in;
   logic [3:0] power_sense_in;
   logic       clk_valid_in;
   wire        scl;
   wire        m_oe;
   wire        sda_out;
   wire        sda_oe;
   wire        irq;
   wire        standby;
   wire        deep;
   wire        clk_en;
   wire  [1:0] mode;
   wire  [1:0] port;
   logic [7:0] q0, q1;
   logic       ack;
   int         n_errors, tests_run, cycles;
   // Pulled-up line, low when either side pulls
   wire        sda = ~m_oe & ~(sda_oe & ~sda_out);

   // Every pin is wired to a bench signal so each rule behind an input can be exercised
   vsw_ctrl_status_regs vsw_ctrl_status_regs_i (
      .ref_clk_in            (ref_clk_in),
      .nrst_in               (nrst_in),
      .scl_in                (scl),
      .sda_in                (sda),
      .sda_out               (sda_out),
      .sda_oe_out            (sda_oe),
      .addr_sel_in           (addr_sel_in),
      .source_power_sense_in (power_sense_in),
      .link_clk_valid_in     (clk_valid_in),
      .irq_out               (irq),
      .power_mode_out        (mode),
      .standby_out           (standby),
      .deep_sleep_mode_out   (deep),
      .active_port_out       (port),
      .clk_detect_en_out     (clk_en)
   );
   vsw_bus_master vsw_bus_master_i (
      .ref_clk_in (ref_clk_in),
      .sda_in     (sda),
      .scl_out    (scl),
      .sda_oe_out (m_oe)
   );

   // ==========================================================
   // Shared helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic       r;
      vsw_bus_master_i.xfer(d, 1'b1, q, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
      vsw_bus_master_i.cond(1'b1);
      send({6'b010110, addr_sel_in, 1'b0});
      chk("write address ack", 8'h01, {7'h0, ack});
      send({4'h0, ofs});
      send(d);
      vsw_bus_master_i.cond(1'b0);
   endtask
   // Pointer phase, then repeated start and one or two data bytes
   task automatic rd(input logic [3:0] ofs, input logic two);
      logic r;
      vsw_bus_master_i.cond(1'b1);
      send({6'b010110, addr_sel_in, 1'b0});
      send({4'h0, ofs});
      vsw_bus_master_i.cond(1'b1);
      send({6'b010110, addr_sel_in, 1'b1});
      chk("read address ack", 8'h01, {7'h0, ack});
      vsw_bus_master_i.xfer(8'hFF, ~two, q0, r);
      if (two) vsw_bus_master_i.xfer(8'hFF, 1'b1, q1, r);
      vsw_bus_master_i.cond(1'b0);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk("irq", 8'h00, {7'h0, irq});
      chk("clk detect en", 8'h01, {7'h0, clk_en});
      rd(4'h2, 1'b0);
      chk("ctrl reset", 8'h00, q0);
   endtask
   task automatic t_addr();
      addr_sel_in <= 1'b1;
      vsw_bus_master_i.cond(1'b1);
      send(8'h58);
      chk("foreign address ack", 8'h00, {7'h0, ack});
      vsw_bus_master_i.cond(1'b0);
      wr(4'h2, 8'h18);
      rd(4'h2, 1'b0);
      chk("ctrl high address", 8'h18, q0);
      addr_sel_in <= 1'b0;
   endtask
   task automatic t_ctrl();
      for (int m = 0; m < 4; m++) begin
         wr(4'h2, {m[1:0], 6'h00});
         chk("power mode", {6'h0, m[1:0]}, {6'h0, mode});
         chk("standby", {7'h0, m == 1}, {7'h0, standby});
         chk("deep sleep", {7'h0, m > 1}, {7'h0, deep});
         rd(4'h2, 1'b0);
         chk("ctrl readback", {m[1:0], 6'h00}, q0);
      end
   endtask
   task automatic t_status();
      power_sense_in <= 4'hA;
      clk_valid_in <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         wr(4'h3, {1'b0, p[1:0], 5'h08});
         rd(4'h1, 1'b1);
         chk("status", {1'b0, p[1:0], 1'b1, 4'hA}, q0);
         chk("next byte", 8'hC0, q1);
         chk("active port", {6'h0, p[1:0]}, {6'h0, port});
      end
      clk_valid_in <= 1'b0;
      rd(4'h1, 1'b0);
      chk("no clock", 8'h6A, q0);
      wr(4'h3, 8'h88);
      rd(4'h1, 1'b0);
      chk("detect off", 8'h1A, q0);
      chk("detect en", 8'h00, {7'h0, clk_en});
      wr(4'h1, 8'hFF);
      rd(4'h1, 1'b0);
      chk("read only", 8'h1A, q0);
   endtask
   task automatic t_irq();
      rd(4'h1, 1'b0);
      chk("irq idle", 8'h00, {7'h0, irq});
      power_sense_in <= 4'h5;
      repeat (8) @(posedge ref_clk_in);
      chk("irq raised", 8'h01, {7'h0, irq});
      rd(4'h2, 1'b0);
      chk("irq held", 8'h01, {7'h0, irq});
      rd(4'h1, 1'b0);
      chk("live status", 8'h15, q0);
      chk("irq cleared", 8'h00, {7'h0, irq});
   endtask
   task automatic auto_case(input logic [7:0] ct, input logic [3:0] pw, input logic [1:0] ex);
      power_sense_in <= pw;
      wr(4'h2, ct);
      rd(4'h1, 1'b0);
      chk("auto port", {6'h0, ex}, {6'h0, port});
      chk("auto status", {1'b0, ex, 1'b1, pw}, q0);
   endtask

   // ==========================================================
   // Clock, main sequence and hang guard
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      nrst_in = 1'b0;
      addr_sel_in = 1'b0;
      power_sense_in = 4'h0;
      clk_valid_in = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      t_reset();
      t_addr();
      t_ctrl();
      t_status();
      t_irq();
      auto_case(8'h30, 4'h4, 2'h2);
      auto_case(8'h30, 4'hA, 2'h1);
      auto_case(8'h38, 4'hF, 2'h3);
      auto_case(8'h20, 4'h8, 2'h3);
      auto_case(8'h00, 4'h8, 2'h0);
      final_report();
   end
   // Whole run needs about 22000 cycles; nearly three times that means a hang
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
endmodule
